// ==== hw/ccmv_regs.vh ====
/*
 * Constants for the codec clocking, mute and volume control block:
 * register addresses, field positions, reset values, ratio codes and counts.
 * Assumes it is included by the design file by its bare name.
 */
`ifndef CCMV_REGS_VH
`define CCMV_REGS_VH

// Register addresses, 7-bit control port space
`define CCMV_ADDR_LEFT1      7'h00
`define CCMV_ADDR_RIGHT1     7'h01
`define CCMV_ADDR_LEFT2      7'h04
`define CCMV_ADDR_RIGHT2     7'h05
`define CCMV_ADDR_LEFT3      7'h06
`define CCMV_ADDR_RIGHT3     7'h07
`define CCMV_ADDR_ALL_CHAN   7'h08
`define CCMV_ADDR_ZERO_FLAG  7'h09
`define CCMV_ADDR_INTERFACE  7'h0a
`define CCMV_ADDR_ADC_OSR    7'h0b
`define CCMV_ADDR_ADC_CTRL   7'h0c
`define CCMV_ADDR_SOFT_RESET 7'h1f

// Field positions
`define CCMV_ATTEN_MSB       7
`define CCMV_UPDATE_BIT      8
`define CCMV_ROLE_BIT        5
`define CCMV_RATIO_MSB       8
`define CCMV_RATIO_LSB       6
`define CCMV_OSR_BIT         8
`define CCMV_HPD_BIT         3
`define CCMV_MPD_BIT         6
`define CCMV_ZSEL_MSB        2
`define CCMV_ZSEL_LSB        1

// Reset values
`define CCMV_ATTEN_RESET     8'hff
`define CCMV_RATIO_RESET     3'h2
`define CCMV_ZSEL_RESET      2'h0

// Ratio codes and master-clock periods per frame
`define CCMV_RATIO_128       3'h0
`define CCMV_RATIO_192       3'h1
`define CCMV_RATIO_256       3'h2
`define CCMV_RATIO_384       3'h3
`define CCMV_RATIO_512       3'h4
`define CCMV_RATIO_768       3'h5
`define CCMV_PERIODS_128     10'h080
`define CCMV_PERIODS_192     10'h0c0
`define CCMV_PERIODS_256     10'h100
`define CCMV_PERIODS_384     10'h180
`define CCMV_PERIODS_512     10'h200
`define CCMV_PERIODS_768     10'h300

// Bit clocks per frame, and zero samples needed for a zero flag
`define CCMV_BITS_PER_FRAME  10'h040
`define CCMV_ZERO_COUNT      11'h400

`endif

// ==== hw/ccmv_control.v ====
/*
 * Control logic of a six-channel codec: frame and bit clock generation or
 * reception, ADC oversampling and highpass control, mute pin decode and
 * staged DAC attenuation. Assumes register writes arrive as one-cycle
 * strobes from the control port logic on clock_in, and that the DAC
 * datapath reports per-channel zero samples on the same clock.
 */
`timescale 1ns/1ns
`include "ccmv_regs.vh"

module ccmv_control (
	input  wire        clock_in,
	input  wire        rst_in,
	input  wire        reg_write_in,
	input  wire [6:0]  reg_addr_in,
	input  wire [8:0]  reg_data_in,
	input  wire        mute_pin_drive_in,
	input  wire        sample_valid_in,
	input  wire [5:0]  sample_zero_in,
	input  wire        mute_pin_in,
	output reg         mute_pin_out,
	output wire        mute_pin_oe_out,
	input  wire        frame_clock_in,
	output reg         frame_clock_out,
	output wire        frame_clock_oe_out,
	input  wire        bit_clock_in,
	output reg         bit_clock_out,
	output wire        bit_clock_oe_out,
	output reg         frame_start_out,
	output reg         bit_edge_out,
	output wire        interface_role_select_out,
	output reg         adc_oversample_64_out,
	output reg         adc_ratio_legal_out,
	output reg         adc_highpass_enable_out,
	output reg  [2:0]  soft_mute_out,
	output reg  [2:0]  zero_flag_out,
	output reg  [5:0]  channel_silent_out,
	output wire [7:0]  left1_attenuation_value_out,
	output wire [7:0]  right1_attenuation_value_out,
	output wire [7:0]  left2_attenuation_value_out,
	output wire [7:0]  right2_attenuation_value_out,
	output wire [7:0]  left3_attenuation_value_out,
	output wire [7:0]  right3_attenuation_value_out
);

	// Channel index for an attenuation address, 3'h7 when not one
	function [2:0] chan_index;
		input [6:0] addr;
		begin
			case (addr)
			`CCMV_ADDR_LEFT1:  chan_index = 3'h0;
			`CCMV_ADDR_RIGHT1: chan_index = 3'h1;
			`CCMV_ADDR_LEFT2:  chan_index = 3'h2;
			`CCMV_ADDR_RIGHT2: chan_index = 3'h3;
			`CCMV_ADDR_LEFT3:  chan_index = 3'h4;
			`CCMV_ADDR_RIGHT3: chan_index = 3'h5;
			default:           chan_index = 3'h7;
			endcase
		end
	endfunction

	// Stereo channels covered by a zero-flag selector code
	function [2:0] zsel_mask;
		input [1:0] sel;
		begin
			case (sel)
			2'h0:    zsel_mask = 3'h7;
			2'h1:    zsel_mask = 3'h1;
			2'h2:    zsel_mask = 3'h2;
			default: zsel_mask = 3'h4;
			endcase
		end
	endfunction

	// Master-clock periods per frame; undefined codes fall back to 256
	function [9:0] ratio_periods;
		input [2:0] code;
		begin
			case (code)
			`CCMV_RATIO_128: ratio_periods = `CCMV_PERIODS_128;
			`CCMV_RATIO_192: ratio_periods = `CCMV_PERIODS_192;
			`CCMV_RATIO_384: ratio_periods = `CCMV_PERIODS_384;
			`CCMV_RATIO_512: ratio_periods = `CCMV_PERIODS_512;
			`CCMV_RATIO_768: ratio_periods = `CCMV_PERIODS_768;
			default:         ratio_periods = `CCMV_PERIODS_256;
			endcase
		end
	endfunction

	wire [47:0] applied_flat;
	reg         interface_role_select;
	reg  [2:0]  ratio_code;
	reg         adc_oversampling_select;
	reg         adc_highpass_bypass;
	reg         mute_pin_decode_disable;
	reg  [1:0]  zero_flag_channel_select;
	reg  [9:0]  frame_count;
	reg  [3:0]  bit_count;
	reg         mute_sync1;
	reg         mute_sync2;
	reg         frame_sync1;
	reg         frame_sync2;
	reg         frame_prev;
	reg         bit_sync1;
	reg         bit_sync2;
	reg         bit_prev;
	reg         gen_bit_prev;
	reg  [2:0]  next_soft_mute;
	reg         mute_level;

	wire [2:0]  wr_chan = chan_index(reg_addr_in);
	wire        wr_all = reg_write_in && (reg_addr_in == `CCMV_ADDR_ALL_CHAN);
	wire        wr_one = reg_write_in && (wr_chan != 3'h7);
	wire        wr_update = reg_data_in[`CCMV_UPDATE_BIT];
	wire [9:0]  periods = ratio_periods(ratio_code);
	wire [9:0]  bit_div_wide = periods / `CCMV_BITS_PER_FRAME;
	wire [3:0]  bit_div = bit_div_wide[3:0];
	wire [2:0]  zero_now;
	wire        zero_flag_sel;

	assign interface_role_select_out = interface_role_select;
	assign frame_clock_oe_out = interface_role_select;
	assign bit_clock_oe_out   = interface_role_select;
	assign mute_pin_oe_out    = mute_pin_drive_in;
	assign left1_attenuation_value_out  = applied_flat[7:0];
	assign right1_attenuation_value_out = applied_flat[15:8];
	assign left2_attenuation_value_out  = applied_flat[23:16];
	assign right2_attenuation_value_out = applied_flat[31:24];
	assign left3_attenuation_value_out  = applied_flat[39:32];
	assign right3_attenuation_value_out = applied_flat[47:40];

	// Control registers; a soft reset write restores every default
	always @(posedge clock_in) begin
		if (rst_in || (reg_write_in && reg_addr_in == `CCMV_ADDR_SOFT_RESET)) begin
			interface_role_select    <= 1'b0;
			ratio_code               <= `CCMV_RATIO_RESET;
			adc_oversampling_select  <= 1'b0;
			adc_highpass_bypass      <= 1'b0;
			mute_pin_decode_disable  <= 1'b0;
			zero_flag_channel_select <= `CCMV_ZSEL_RESET;
		end else if (reg_write_in) begin
			case (reg_addr_in)
			`CCMV_ADDR_INTERFACE: begin
				interface_role_select <= reg_data_in[`CCMV_ROLE_BIT];
				ratio_code <= reg_data_in[`CCMV_RATIO_MSB:`CCMV_RATIO_LSB];
			end
			`CCMV_ADDR_ADC_OSR: begin
				adc_oversampling_select <= reg_data_in[`CCMV_OSR_BIT];
			end
			`CCMV_ADDR_ADC_CTRL: begin
				adc_highpass_bypass     <= reg_data_in[`CCMV_HPD_BIT];
				mute_pin_decode_disable <= reg_data_in[`CCMV_MPD_BIT];
			end
			`CCMV_ADDR_ZERO_FLAG: begin
				zero_flag_channel_select <= reg_data_in[`CCMV_ZSEL_MSB:`CCMV_ZSEL_LSB];
			end
			default: begin
				interface_role_select <= interface_role_select;
			end
			endcase
		end
	end

	// Staged and applied attenuation per channel. The written value goes to
	// the stage and, on update, straight to the output, so an update write
	// never applies the stale stage of its own channel.
	genvar ch;
	generate
		for (ch = 0; ch < 6; ch = ch + 1) begin : g_atten
			wire hit = wr_all || (wr_one && wr_chan == ch);
			reg  [7:0] stage;
			reg  [7:0] applied;
			assign applied_flat[8*ch +: 8] = applied;
			always @(posedge clock_in) begin
				if (rst_in || (reg_write_in && reg_addr_in == `CCMV_ADDR_SOFT_RESET)) begin
					stage   <= `CCMV_ATTEN_RESET;
					applied <= `CCMV_ATTEN_RESET;
				end else begin
					if (hit)
						stage <= reg_data_in[`CCMV_ATTEN_MSB:0];
					if ((wr_all || wr_one) && wr_update) begin
						if (hit)
							applied <= reg_data_in[`CCMV_ATTEN_MSB:0];
						else
							applied <= stage;
					end
				end
			end
		end
	endgenerate

	// Code 00 is full mute; other codes leave the datapath to scale
	always @(posedge clock_in) begin : silent_proc
		integer i;
		if (rst_in) begin
			channel_silent_out <= 6'h00;
		end else begin
			for (i = 0; i < 6; i = i + 1)
				channel_silent_out[i] <= (applied_flat[8*i +: 8] == 8'h00);
		end
	end

	// Zero-run counters per stereo channel, saturating at the flag count
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_zero
			reg  [10:0] run;
			assign zero_now[ch] = (run == `CCMV_ZERO_COUNT);
			always @(posedge clock_in) begin
				if (rst_in) begin
					run <= 11'h000;
				end else if (sample_valid_in) begin
					if (!(sample_zero_in[2*ch] && sample_zero_in[2*ch+1]))
						run <= 11'h000;
					else if (!zero_now[ch])
						run <= run + 11'h001;
				end
			end
		end
	endgenerate

	// Selected zero condition: all chosen channels must be flagged
	assign zero_flag_sel = &(zero_now | ~zsel_mask(zero_flag_channel_select));

	// Mute pin synchroniser; the first stage feeds only the second
	always @(posedge clock_in) begin
		if (rst_in) begin
			mute_sync1 <= 1'b0;
			mute_sync2 <= 1'b0;
		end else begin
			mute_sync1 <= mute_pin_in;
			mute_sync2 <= mute_sync1;
		end
	end

	// Mute decode. When driving, the driven flag itself is the pin level,
	// so a zero run on the selected channels mutes those channels (all three with decode disabled) with no pin loop.
	always @* begin
		mute_level = mute_pin_drive_in ? mute_pin_out : mute_sync2;
		if (!mute_level)
			next_soft_mute = 3'h0;
		else if (mute_pin_decode_disable)
			next_soft_mute = 3'h7;
		else
			next_soft_mute = zsel_mask(zero_flag_channel_select);
	end

	// Registered mute and flag outputs
	always @(posedge clock_in) begin
		if (rst_in) begin
			mute_pin_out  <= 1'b0;
			soft_mute_out <= 3'h0;
			zero_flag_out <= 3'h0;
		end else begin
			mute_pin_out  <= zero_flag_sel;
			soft_mute_out <= next_soft_mute;
			zero_flag_out <= zero_now;
		end
	end

	// ADC controls. 64x needs a ratio that supports 96kHz; low ratios are
	// flagged so the ADC path is held off them.
	always @(posedge clock_in) begin
		if (rst_in) begin
			adc_oversample_64_out   <= 1'b0;
			adc_ratio_legal_out     <= 1'b1;
			adc_highpass_enable_out <= 1'b1;
		end else begin
			adc_oversample_64_out <= adc_oversampling_select &&
				(periods == `CCMV_PERIODS_256 || periods == `CCMV_PERIODS_384);
			adc_ratio_legal_out <= (periods != `CCMV_PERIODS_128) &&
				(periods != `CCMV_PERIODS_192);
			adc_highpass_enable_out <= !adc_highpass_bypass;
		end
	end

	// Generator: divide the master clock into bit and frame clocks. Counters
	// idle in receiver role so a role change starts a clean frame.
	always @(posedge clock_in) begin
		if (rst_in || !interface_role_select) begin
			frame_count     <= 10'h000;
			bit_count       <= 4'h0;
			frame_clock_out <= 1'b0;
			bit_clock_out   <= 1'b0;
		end else begin
			if (frame_count >= periods - 10'h001) begin
				frame_count <= 10'h000;
				bit_count   <= 4'h0;
			end else begin
				frame_count <= frame_count + 10'h001;
				if (bit_count >= bit_div - 4'h1)
					bit_count <= 4'h0;
				else
					bit_count <= bit_count + 4'h1;
			end
			frame_clock_out <= (frame_count < {1'b0, periods[9:1]});
			bit_clock_out   <= (bit_count >= {1'b0, bit_div[3:1]});
		end
	end

	// Receiver: synchronise the partner's clocks before edge detection
	always @(posedge clock_in) begin
		if (rst_in) begin
			frame_sync1 <= 1'b0;
			frame_sync2 <= 1'b0;
			frame_prev  <= 1'b0;
			bit_sync1   <= 1'b0;
			bit_sync2   <= 1'b0;
			bit_prev    <= 1'b0;
		end else begin
			frame_sync1 <= frame_clock_in;
			frame_sync2 <= frame_sync1;
			frame_prev  <= frame_sync2;
			bit_sync1   <= bit_clock_in;
			bit_sync2   <= bit_sync1;
			bit_prev    <= bit_sync2;
		end
	end

	// Frame and bit edge pulses from whichever side owns the clocks
	always @(posedge clock_in) begin
		if (rst_in) begin
			frame_start_out <= 1'b0;
			bit_edge_out    <= 1'b0;
			gen_bit_prev    <= 1'b0;
		end else begin
			gen_bit_prev <= bit_clock_out;
			if (interface_role_select) begin
				frame_start_out <= (frame_count == 10'h000);
				bit_edge_out    <= bit_clock_out && !gen_bit_prev;
			end else begin
				frame_start_out <= frame_sync2 && !frame_prev;
				bit_edge_out    <= bit_sync2 && !bit_prev;
			end
		end
	end

endmodule

// ==== sim/ccmv_props.sv ====
/* Port-level assertions for the codec control block.
   Assumes it is bound to ccmv_control and sees only its ports. */
`timescale 1ns/1ns
module ccmv_props (
	input wire       clock_in,
	input wire       rst_in,
	input wire       reg_write_in,
	input wire [6:0] reg_addr_in,
	input wire [8:0] reg_data_in,
	input wire       mute_pin_drive_in,
	input wire       sample_valid_in,
	input wire [5:0] sample_zero_in,
	input wire       mute_pin_oe_out,
	input wire       frame_clock_out,
	input wire       frame_clock_oe_out,
	input wire       bit_clock_out,
	input wire       bit_clock_oe_out,
	input wire       interface_role_select_out,
	input wire [2:0] zero_flag_out,
	input wire [5:0] channel_silent_out,
	input wire [7:0] left1_attenuation_value_out,
	input wire [7:0] right3_attenuation_value_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	// Clock pin drivers follow the role bit, the mute pin driver its drive input; receiver role keeps clocks quiet
	role_oe_a: assert property (frame_clock_oe_out == interface_role_select_out
		&& bit_clock_oe_out == interface_role_select_out) else $error("clock enable mismatch");
	recv_idle_a: assert property (!interface_role_select_out &&
		!$past(interface_role_select_out) |-> !frame_clock_out && !bit_clock_out)
		else $error("clock driven in receiver role");
	mute_oe_a: assert property (mute_pin_oe_out == mute_pin_drive_in)
		else $error("mute pin enable mismatch");

	// Staging writes leave applied values alone; update writes apply them
	stage_hold_a: assert property (reg_write_in && !reg_data_in[8] &&
		reg_addr_in != 7'h1f |=> $stable(left1_attenuation_value_out)
		&& $stable(right3_attenuation_value_out)) else $error("staged write applied");
	all_apply_a: assert property (reg_write_in && reg_addr_in == 7'h08 &&
		reg_data_in[8] |=> left1_attenuation_value_out == $past(reg_data_in[7:0])
		&& right3_attenuation_value_out == $past(reg_data_in[7:0])) else $error("all load");
	one_apply_a: assert property (reg_write_in && reg_addr_in == 7'h00 &&
		reg_data_in[8] |=> left1_attenuation_value_out == $past(reg_data_in[7:0]))
		else $error("update write lost");
	silent_map_a: assert property (channel_silent_out[0] ==
		($past(left1_attenuation_value_out) == 8'h00)) else $error("silent flag wrong");

	// Zero flag only rises on a sample and drops on a nonzero pair
	zero_rise_a: assert property ($rose(zero_flag_out[0]) |->
		$past(sample_valid_in, 2)) else $error("zero flag without sample");
	zero_clear_a: assert property (sample_valid_in && !(&sample_zero_in[1:0])
		|=> ##1 !zero_flag_out[0]) else $error("zero flag survived nonzero");

	cover property ($rose(zero_flag_out[0]));
	cover property ($rose(frame_clock_oe_out));
	cover property (reg_write_in && reg_addr_in == 7'h08 && reg_data_in[8]);
endmodule

bind ccmv_control ccmv_props u_props (.*);

// ==== sim/ccmv_partner.sv ====
/* Audio processor supplying frame and bit clocks in receiver role.
   Assumes the bench selects the device's drivers whenever it generates. */
`timescale 1ns/1ns
module ccmv_partner (
	input  wire enable_in,
	output reg  frame_clock_out,
	output reg  bit_clock_out
);
	integer n;

	// Whole frames of 64 bit clocks, frame high for the first half; stands still when idle.
	// Edges sit a quarter period off the device clock so its samplers never race them.
	initial begin
		bit_clock_out = 1'b0;
		frame_clock_out = 1'b0;
		#37;
		forever begin
			wait (enable_in);
			#25;
			while (enable_in) begin
				for (n = 0; n < 64; n = n + 1) begin
					frame_clock_out = (n < 32);
					#150 bit_clock_out = 1'b1;
					#150 bit_clock_out = 1'b0;
				end
			end
		end
	end
endmodule

// ==== sim/testbench.sv ====
/* Self-checking bench for ccmv_control with a register model.
   Assumes the partner module and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module testbench;
	reg         clock_in, rst_in, reg_write_in, mute_pin_drive_in;
	reg         sample_valid_in, mute_pin_in;
	reg  [6:0]  reg_addr_in;
	reg  [8:0]  reg_data_in;
	reg  [5:0]  sample_zero_in;
	reg  [15:0] lf;
	wire        mute_pin_out, mute_pin_oe_out, frame_clock_out, frame_clock_oe_out;
	wire        bit_clock_out, bit_clock_oe_out, frame_start_out, bit_edge_out;
	wire        interface_role_select_out, adc_oversample_64_out, adc_ratio_legal_out;
	wire        adc_highpass_enable_out, p_frame, p_bit;
	wire [2:0]  soft_mute_out, zero_flag_out;
	wire [5:0]  channel_silent_out;
	wire [7:0]  left1_attenuation_value_out, right1_attenuation_value_out;
	wire [7:0]  left2_attenuation_value_out, right2_attenuation_value_out;
	wire [7:0]  left3_attenuation_value_out, right3_attenuation_value_out;
	wire [47:0] atts = {right3_attenuation_value_out, left3_attenuation_value_out,
		right2_attenuation_value_out, left2_attenuation_value_out,
		right1_attenuation_value_out, left1_attenuation_value_out};
	// Shared clock pins resolve to whichever side drives them
	wire        frame_clock_in = frame_clock_oe_out ? frame_clock_out : p_frame;
	wire        bit_clock_in = bit_clock_oe_out ? bit_clock_out : p_bit;
	integer     n_mismatch, tests_run, cyc, k, e, stg [0:5], app [0:5];

	ccmv_control u_ccmv_control (.*);
	ccmv_partner u_ccmv_partner (.enable_in(!interface_role_select_out),
		.frame_clock_out(p_frame), .bit_clock_out(p_bit));

	// Free-running 10 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	function [15:0] lfsr(input [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task chk(input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// One-cycle write strobe, then the model takes the same write
	task wr(input [6:0] a, input [8:0] d);
		integer i;
		begin
			@(posedge clock_in);
			reg_write_in <= 1'b1;
			reg_addr_in <= a;
			reg_data_in <= d;
			@(posedge clock_in);
			reg_write_in <= 1'b0;
			for (i = 0; i < 6; i = i + 1) begin
				if (a == 7'h08 || a == ((i < 2) ? i : i + 2))
					stg[i] = d[7:0];
				if (a == 7'h1f)
					stg[i] = 255;
			end
			for (i = 0; i < 6; i = i + 1)
				if (a == 7'h1f || (d[8] && a <= 7'h08 && a != 7'h02 && a != 7'h03))
					app[i] = stg[i];
		end
	endtask

	task chk_att;
		integer i;
		begin
			repeat (2) @(posedge clock_in);
			#1;
			for (i = 0; i < 6; i = i + 1) begin
				chk(atts[i*8 +: 8], app[i]);
				chk(channel_silent_out[i], app[i] == 0);
			end
		end
	endtask

	task smp(input [5:0] z);
		begin
			@(posedge clock_in);
			sample_valid_in <= 1'b1;
			sample_zero_in <= z;
			@(posedge clock_in);
			sample_valid_in <= 1'b0;
		end
	endtask

	// Skips two frame starts, then counts one whole frame and its high half
	task per(input integer exp);
		integer c, b, h, j;
		begin
			for (j = 0; j < 3; j = j + 1) begin
				c = 0;
				b = 0;
				h = 0;
				do begin
					@(posedge clock_in);
					#1;
					c = c + 1;
					b = b + bit_edge_out;
					h = h + frame_clock_in;
				end while (frame_start_out !== 1'b1 && c < 2000);
			end
			chk(c, exp);
			chk(b, 64);
			chk(h, exp / 2);
		end
	endtask

	task print_verdict;
		begin
			$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
			if (n_mismatch == 0 && tests_run > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	// Hang guard
	always @(posedge clock_in) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end

	// Main sequence
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		cyc = 0;
		lf = 16'd3920;
		{rst_in, reg_write_in, mute_pin_drive_in, sample_valid_in, mute_pin_in} = 5'h10;
		reg_addr_in = 7'h00;
		reg_data_in = 9'h000;
		sample_zero_in = 6'h00;
		for (k = 0; k < 6; k = k + 1) begin
			stg[k] = 255;
			app[k] = 255;
		end
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		chk_att;
		chk({interface_role_select_out, frame_clock_oe_out, adc_oversample_64_out,
			adc_ratio_legal_out, adc_highpass_enable_out}, 5'h03);
		// Random staging and updates, with a mute code and a master load
		for (k = 0; k < 16; k = k + 1) begin
			lf = lfsr(lf);
			e = lf[2:0] % 6;
			wr((k % 5 == 3) ? 7'h08 : ((e < 2) ? e : e + 2), (k == 5) ? 9'h100 : lf[12:4]);
			chk_att;
		end
		wr(7'h08, 9'h1fe);
		chk_att;
		wr(7'h1f, 9'h000);
		chk_att;
		// Every ratio code with and without the oversampling bit
		for (k = 0; k < 16; k = k + 1) begin
			wr(7'h0a, {k[2:0], 6'h00});
			wr(7'h0b, {k[3], 8'h00});
			wr(7'h0c, {5'h00, k[0], 3'h0});
			repeat (2) @(posedge clock_in);
			#1;
			e = (k[2:0] > 5) ? 2 : k[2:0];
			chk(adc_oversample_64_out, k[3] && (e == 2 || e == 3));
			chk(adc_ratio_legal_out, e > 1);
			chk(adc_highpass_enable_out, !k[0]);
		end
		// Generator role at every ratio code
		for (k = 0; k < 8; k = k + 1) begin
			wr(7'h0a, {k[2:0], 6'h20});
			e = (k > 5) ? 2 : k;
			per(((e & 1) ? 192 : 128) << (e >> 1));
			chk({frame_clock_oe_out, bit_clock_oe_out}, 2'h3);
		end
		wr(7'h0a, 9'h080);
		per(192);
		// Mute pin as output, channel 1 zero detect
		@(posedge clock_in);
		mute_pin_drive_in <= 1'b1;
		wr(7'h09, 9'h002);
		for (k = 0; k < 1023; k = k + 1)
			smp(6'h3f);
		repeat (4) @(posedge clock_in);
		#1;
		chk(zero_flag_out, 3'h0);
		smp(6'h3f);
		repeat (4) @(posedge clock_in);
		#1;
		chk(zero_flag_out, 3'h7);
		chk(mute_pin_out, 1);
		chk(soft_mute_out, 3'h1);
		smp(6'h33);
		wr(7'h09, 9'h004);
		repeat (4) @(posedge clock_in);
		#1;
		chk(zero_flag_out, 3'h5);
		chk(mute_pin_out, 0);
		// Mute pin as input, decoded then undecoded
		@(posedge clock_in);
		mute_pin_drive_in <= 1'b0;
		mute_pin_in <= 1'b1;
		repeat (5) @(posedge clock_in);
		#1;
		chk(soft_mute_out, 3'h2);
		wr(7'h0c, 9'h040);
		repeat (5) @(posedge clock_in);
		#1;
		chk(soft_mute_out, 3'h7);
		// A nonzero pair on channel 1 drops its standing flag
		smp(6'h3c);
		repeat (4) @(posedge clock_in);
		#1;
		chk(zero_flag_out, 3'h4);
		print_verdict;
	end
endmodule
